// ==== bench/fpm_bus_checker.sv ====
// Concurrent checks on the ports of the memory and bus control block.
// Assumes it is bound to fpm_bus_ctrl; one clock, synchronous reset.
`timescale 1ns/1ps
module fpm_bus_checker import fpm_pkg::*; (
  // Processor and DMA
  input wire logic        CLK,
  input wire logic        SRST,
  input wire logic        CPU_REQ,
  input wire logic        CPU_IO,
  input wire logic        CPU_WR,
  input wire logic [19:0] CPU_ADDR,
  input wire logic [15:0] CPU_WDATA,
  input wire logic        CPU_READY,
  input wire logic        DMA_REQ,
  input wire logic        DMA_ACK,
  // System bus and board
  input wire logic [23:0] SYS_ADDR,
  input wire logic        SYS_MRDC_N,
  input wire logic        SYS_MWTC_N,
  input wire logic        UPPER_WORD_ENABLE_N,
  input wire logic        BYTE_ADDRESS_BIT0,
  input wire logic        SYS_BUSY_OE_N,
  input wire logic        SYSTEM_BUS_LOCK_N,
  input wire logic        HOST_CPU_INTERRUPT_N,
  input wire logic        NMI,
  input wire logic        CONTROLLER_BOARD_CLEAR_N
);
  // ==========================================
  // Helpers
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  logic       gate;
  logic [8:0] clr_cnt;
  wire        cmd_done = CPU_REQ && CPU_IO && CPU_WR && CPU_READY && CPU_ADDR[15:0] == CMD_OFS;
  wire        bus_cmd  = !SYS_MRDC_N || !SYS_MWTC_N;
  sequence s_cmd_wr;
    cmd_done ##2 1'b1;
  endsequence
  sequence s_tie;
    $rose(DMA_REQ) && $rose(CPU_REQ);
  endsequence
  always_ff @(posedge CLK) begin
    if (SRST)
      gate <= 1'b0;
    else if (cmd_done)
      gate <= CPU_WDATA[CMD_NMI_BIT];
  end
  // Saturates so a stuck clear cannot wrap back below the minimum
  always_ff @(posedge CLK) begin
    if (SRST || CONTROLLER_BOARD_CLEAR_N)
      clr_cnt <= 9'h000;
    else if (clr_cnt != 9'h1ff)
      clr_cnt <= clr_cnt + 9'h001;
  end
  // ==========================================
  // Assertions
  a_lock_follows_cmd:
    assert property (s_cmd_wr |-> SYSTEM_BUS_LOCK_N == !$past(CPU_WDATA[CMD_LOCK_BIT], 2))
      else $error("bus lock does not follow command write");
  a_host_int_cmd:
    assert property (s_cmd_wr |-> HOST_CPU_INTERRUPT_N == !$past(CPU_WDATA[CMD_HINT_BIT], 2))
      else $error("host interrupt does not follow command write");
  a_nmi_needs_gate:
    assert property ($rose(NMI) |-> gate)
      else $error("error interrupt while gate closed");
  a_dma_wins_tie:
    assert property (s_tie |-> !CPU_READY until_with DMA_ACK)
      else $error("processor served before DMA on a tie");
  a_dma_ack_bound:
    assert property ($rose(DMA_REQ) |-> ##[1:80] DMA_ACK)
      else $error("DMA transfer not acknowledged");
  a_width_encode:
    assert property (bus_cmd |-> BYTE_ADDRESS_BIT0 == SYS_ADDR[0]
                     && UPPER_WORD_ENABLE_N == !SYS_ADDR[1])
      else $error("width signals disagree with address");
  a_cmd_owns_bus:
    assert property (bus_cmd |-> !SYS_BUSY_OE_N && SYS_MRDC_N != SYS_MWTC_N)
      else $error("bus command without ownership");
  a_clear_stretch:
    assert property ($rose(CONTROLLER_BOARD_CLEAR_N) |-> clr_cnt >= CLR_MIN_CYC)
      else $error("board clear too short");
endmodule // fpm_bus_checker

bind fpm_bus_ctrl fpm_bus_checker fpm_bus_checker_inst (
  .CLK, .SRST, .CPU_REQ, .CPU_IO, .CPU_WR, .CPU_ADDR, .CPU_WDATA, .CPU_READY,
  .DMA_REQ, .DMA_ACK, .SYS_ADDR, .SYS_MRDC_N, .SYS_MWTC_N, .UPPER_WORD_ENABLE_N,
  .BYTE_ADDRESS_BIT0, .SYS_BUSY_OE_N, .SYSTEM_BUS_LOCK_N, .HOST_CPU_INTERRUPT_N,
  .NMI, .CONTROLLER_BOARD_CLEAR_N
);

// ==== bench/fpm_sysbus_model.sv ====
// Behavioural model of the shared system bus: arbiter and a memory slave.
// Assumes one clock; slow adds another master's tenure and late acknowledges.
`timescale 1ns/1ps
module fpm_sysbus_model import fpm_pkg::*; (
  // Control
  input  wire logic clk,
  input  wire logic slow,
  // Board side
  input  wire logic breq0_n,
  input  wire logic busy_oe_n,
  input  wire logic busy_n_out,
  input  wire logic mrdc_n,
  input  wire logic mwtc_n,
  // Bus side
  output logic      bprn_n,
  output logic      busy_n_in,
  output logic      xack_n
);
  // ==========================================
  // Arbitration
  logic [3:0] req_age = 4'h0;
  logic [3:0] cmd_age = 4'h0;
  always_ff @(posedge clk) begin
    bprn_n <= breq0_n;
  end
  always_ff @(posedge clk) begin
    req_age <= breq0_n ? 4'h0 : req_age + {3'h0, req_age != 4'hf};
  end
  // Wired busy line: another master may still hold it when slow
  assign busy_n_in = !(slow && !breq0_n && req_age < 4'h5) && (busy_oe_n || busy_n_out);
  // ==========================================
  // Memory slave; the pulled-up acknowledge goes high as soon as the command ends
  always_ff @(posedge clk) begin
    cmd_age <= (mrdc_n && mwtc_n) ? 4'h0 : cmd_age + 4'h1;
  end
  assign xack_n = !((!mrdc_n || !mwtc_n) && cmd_age >= (slow ? 4'h6 : 4'h1));
endmodule // fpm_sysbus_model

// ==== bench/test_file_processor_memory_bus_control.sv ====
// Self-checking bench for the memory and bus control block.
// Assumes the bus model answers; inputs change by NBA at rising edges.
`timescale 1ns/1ps
module test_file_processor_memory_bus_control import fpm_pkg::*; ;
  // ==========================================
  // Signals
  logic        CLK = 1'b0, SRST = 1'b1, CPU_REQ = 1'b0, CPU_IO = 1'b0, CPU_WR = 1'b0;
  logic        CPU_BHE_N = 1'b1, DMA_REQ = 1'b0, DMA_WR = 1'b0, DMA_WORD = 1'b0;
  logic        RAM_PARITY_ERR = 1'b0, SYS_PARITY_ERR = 1'b0, SYS_BOUNDS_ERR = 1'b0;
  logic        POWER_FAIL = 1'b0, PROM_LARGE = 1'b0, RAM_LARGE = 1'b0, SYS_IOWC_N = 1'b1;
  logic        slow = 1'b0, CPU_READY, DMA_ACK, RAM_RAS_N, RAM_CAS_N, RAM_WE_N, PROM_SEL_N;
  logic        SYS_MRDC_N, SYS_MWTC_N, UPPER_BYTE_ENABLE_N, UPPER_WORD_ENABLE_N, NMI;
  logic        BYTE_ADDRESS_BIT0, SYS_BREQ0_N, SYS_BPRN_N, SYS_BUSY_N_IN, SYS_BUSY_N_OUT;
  logic        SYS_BUSY_OE_N, SYSTEM_BUS_LOCK_N, SYS_XACK_N, HOST_CPU_INTERRUPT_N;
  logic        XCVR_LO_EN_N, XCVR_HI_EN_N, XCVR_TO_BUS, CHAN_ATTN_IRQ;
  logic        CONTROLLER_BOARD_CLEAR_N, DMA_BURST_LIMIT_ENABLE, cap_ube, cap_a0, cap_wr;
  logic [19:0] CPU_ADDR = 20'h00000;
  logic [15:0] CPU_WDATA = 16'h0000, SYS_IO_ADDR = 16'h0000, CPU_RDATA, DISK_MODE, rd;
  logic [23:0] DMA_ADDR = 24'h000000, SYS_ADDR, cap_addr;
  int          error_cnt = 0, checks = 0, cyc = 0, n_prom = 0, n_breq = 0, n_attn = 0, lat;
  time         t_ack, t_rdy;

  fpm_bus_ctrl fpm_bus_ctrl_inst (.*);
  fpm_sysbus_model fpm_sysbus_model_inst (
    .clk(CLK), .slow(slow), .breq0_n(SYS_BREQ0_N), .busy_oe_n(SYS_BUSY_OE_N),
    .busy_n_out(SYS_BUSY_N_OUT), .mrdc_n(SYS_MRDC_N), .mwtc_n(SYS_MWTC_N),
    .bprn_n(SYS_BPRN_N), .busy_n_in(SYS_BUSY_N_IN), .xack_n(SYS_XACK_N));

  initial begin
    forever #50 CLK = ~CLK;
  end
  // Activity monitor; also cuts a hang short
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    n_prom <= n_prom + int'(!PROM_SEL_N);
    n_breq <= n_breq + int'(!SYS_BREQ0_N);
    n_attn <= n_attn + int'(CHAN_ATTN_IRQ);
    if (!SYS_MRDC_N || !SYS_MWTC_N) begin
      cap_addr <= SYS_ADDR;
      cap_ube <= UPPER_BYTE_ENABLE_N;
      cap_a0 <= BYTE_ADDRESS_BIT0;
      cap_wr <= !SYS_MWTC_N && XCVR_TO_BUS;
    end
    if (cyc == 40000) begin
      error_cnt++;
      $display("unexpected at %0t: run too long", $time);
      end_sim;
    end
  end
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cpu(input logic io, input logic wr, input logic bhe_n, input logic [19:0] a,
                     input logic [15:0] d);
    lat = 0;
    @(posedge CLK);
    CPU_REQ <= 1'b1;
    CPU_IO <= io;
    CPU_WR <= wr;
    CPU_BHE_N <= bhe_n;
    CPU_ADDR <= a;
    CPU_WDATA <= d;
    do begin
      @(posedge CLK);
      lat++;
    end while (CPU_READY !== 1'b1 && lat < 200);
    rd = CPU_RDATA;
    t_rdy = $time;
    CPU_REQ <= 1'b0;
    chk(24'(lat < 200), 24'h1);
  endtask
  task automatic io(input logic wr, input logic [15:0] a, input logic [15:0] d);
    cpu(1'b1, wr, 1'b1, {4'h0, a}, d);
    repeat (2) @(posedge CLK);
  endtask
  task automatic dma(input logic wr, input logic word, input logic [23:0] a);
    int n = 0;
    @(posedge CLK);
    DMA_REQ <= 1'b1;
    DMA_WR <= wr;
    DMA_WORD <= word;
    DMA_ADDR <= a;
    do begin
      @(posedge CLK);
      n++;
    end while (DMA_ACK !== 1'b1 && n < 200);
    t_ack = $time;
    DMA_REQ <= 1'b0;
    chk({cap_addr}, a);
    chk({cap_wr, cap_ube, cap_a0}, {wr, !(word || a[0]), a[0]});
  endtask
  task automatic host_wr(input logic [15:0] a);
    @(posedge CLK);
    SYS_IO_ADDR <= a;
    repeat (2) @(posedge CLK);
    SYS_IOWC_N <= 1'b0;
    repeat (4) @(posedge CLK);
    SYS_IOWC_N <= 1'b1;
    repeat (8) @(posedge CLK);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_cmd;
    chk({DISK_MODE, SYSTEM_BUS_LOCK_N, HOST_CPU_INTERRUPT_N, NMI}, 24'h00006);
    io(1'b1, CMD_OFS, 16'h3fff);
    chk({HOST_CPU_INTERRUPT_N, DMA_BURST_LIMIT_ENABLE, SYSTEM_BUS_LOCK_N}, 24'h2);
    io(1'b1, CMD_OFS, 16'h0100);
    chk({HOST_CPU_INTERRUPT_N, DMA_BURST_LIMIT_ENABLE, SYSTEM_BUS_LOCK_N}, 24'h5);
    io(1'b1, DISK_OFS, 16'ha55a);
    io(1'b0, DISK_OFS, 16'h0000);
    chk({DISK_MODE, rd}, {16'ha55a, 16'h0000});
    io(1'b0, CMD_OFS, 16'h0000);
    chk(rd, 24'h0);
  endtask
  task automatic t_errors;
    logic [15:0] exp_st [4] = '{16'h0100, 16'h0200, 16'h0200, 16'h0400};
    for (int i = 0; i < 4; i++) begin
      io(1'b1, CMD_OFS, {4'h0, i[0], 11'h100});
      {POWER_FAIL, SYS_PARITY_ERR, SYS_BOUNDS_ERR, RAM_PARITY_ERR} <= 4'h8 >> i;
      repeat (3) @(posedge CLK);
      {POWER_FAIL, SYS_PARITY_ERR, SYS_BOUNDS_ERR, RAM_PARITY_ERR} <= 4'h0;
      repeat (6) @(posedge CLK);
      chk(NMI, i[0]);
      io(1'b0, STAT_OFS, 16'h0000);
      chk(rd, exp_st[i]);
      io(1'b1, ERROR_FLAGS_CLEAR_OFS, 16'h0000);
      io(1'b0, STAT_OFS, 16'h0000);
      chk({NMI, rd}, 24'h0);
    end
  endtask
  task automatic t_clear;
    int n = 0;
    io(1'b1, CMD_OFS, 16'h0000);
    repeat (260) @(posedge CLK);
    chk(CONTROLLER_BOARD_CLEAR_N, 24'h0);
    io(1'b1, CMD_OFS, 16'h0100);
    while (CONTROLLER_BOARD_CLEAR_N !== 1'b1 && n < 500) begin
      @(posedge CLK);
      n++;
    end
    chk(24'(n >= CLR_MIN_CYC - 4 && n < 500), 24'h1);
  endtask
  task automatic t_decode;
    // Jumpers, kind (0 none, 1 RAM, 2 PROM, 3 system), BHE_N, address
    logic [24:0] tab [10] = '{
      {4'h0, 1'b1, 20'h48000}, {4'h1, 1'b0, 20'h00100}, {4'h0, 1'b1, 20'h10000},
      {4'h9, 1'b1, 20'h10000}, {4'h2, 1'b1, 20'hfe001}, {4'h0, 1'b1, 20'hfc000},
      {4'h6, 1'b1, 20'hfc000}, {4'h3, 1'b0, 20'h81234}, {4'h3, 1'b0, 20'hbfff7},
      {4'h3, 1'b1, 20'h80002}};
    int np, nb;
    io(1'b1, PAGE_OFS, 16'h002a);
    foreach (tab[i]) begin
      {RAM_LARGE, PROM_LARGE} <= tab[i][24:23];
      repeat (3) @(posedge CLK);
      np = n_prom;
      nb = n_breq;
      cpu(1'b0, tab[i][1], tab[i][20], tab[i][19:0], 16'h5aa5);
      chk({n_prom > np, n_breq > nb},
          {tab[i][22:21] == 2'd2, tab[i][22:21] == 2'd3});
      if (tab[i][22:21] == 2'd1)
        chk(24'(lat >= 4), 24'h1);
      if (tab[i][22:21] == 2'd3)
        chk({cap_addr, cap_ube, cap_a0},
            {6'h2a, tab[i][17:0], tab[i][20] && !tab[i][0], tab[i][0]});
    end
  endtask
  task automatic t_dma;
    int n;
    dma(1'b0, 1'b1, 24'hfedcbc);
    slow <= 1'b1;
    dma(1'b1, 1'b0, 24'h000001);
    slow <= 1'b0;
    fork
      dma(1'b1, 1'b1, 24'h123456);
      cpu(1'b0, 1'b0, 1'b0, 20'h00200, 16'h0000);
    join
    chk(24'(t_ack < t_rdy), 24'h1);
    n = n_attn;
    host_wr(ATTN_ADDR);
    host_wr(16'h000c);
    chk(24'(n_attn - n), 24'h1);
  endtask
  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    SRST <= 1'b0;
    t_cmd;
    t_errors;
    t_clear;
    t_decode;
    t_dma;
    end_sim;
  end
endmodule // test_file_processor_memory_bus_control

// ==== rtl/fpm_bus_ctrl.sv ====
// Memory decode, local arbitration and system-bus control of the file processor.
// Processor and DMA requests are on CLK; bus, error and jumper pins are asynchronous.
`timescale 1ns/1ps

// What this block does
// - Only the lower 16 system bus data lines carry the board's transfers.
// - Request the bus on request line 0 with top priority.
// - Host write to I/O 000Eh becomes a local attention interrupt.
// - DMA reaches all system memory with a 24-bit address.
// - Six-bit page register supplies upper system address bits.
// - One master at a time; DMA beats processor on a tie.
// - Byte and word accesses for both processor and DMA.
// - Processor reaches PROM, RAM, system memory; DMA system memory only.
// - Top two address bits: 00 RAM, 10 system, 11 PROM, 01 unused.
// - Window 80000h to BFFFFh maps to system memory through the page.
// - PROM 8K or 16K, local RAM 32K or 128K decoded.
// - RAM controller makes RAS/CAS, refresh arbitration and wait states.
// - Local parity, system parity, out-of-bounds errors raise NMI.
// - Bus read/write strobes plus width signals encode transfer width.
// - Bus exchange handled and data transceivers steered per transfer.
// - Command 0608 write, disk mode 060C write, status 0700 read.
// - Command bit 8 low clears controller board, at least 25 us.
// - Command bit 10 interrupts the host on bus interrupt line 0.
// - Command bit 11 gates error NMIs to the local processor.
// - Command bit 12 enables DMA burst limiting.
// - Command bit 13 asserts bus lock to keep the bus.
// - Reset clears the NMI gate.
// - I/O write to 0606h clears the latched error flags.
// - Status bits 8 power fail, 9 system error, 10 parity; 14-15 zero.
module fpm_bus_ctrl import fpm_pkg::*; (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        SRST,
  // Local processor
  input  wire logic        CPU_REQ,
  input  wire logic        CPU_IO,
  input  wire logic        CPU_WR,
  input  wire logic        CPU_BHE_N,
  input  wire logic [19:0] CPU_ADDR,
  input  wire logic [15:0] CPU_WDATA,
  output logic             CPU_READY,
  output logic      [15:0] CPU_RDATA,
  // DMA controller
  input  wire logic        DMA_REQ,
  input  wire logic        DMA_WR,
  input  wire logic        DMA_WORD,
  input  wire logic [23:0] DMA_ADDR,
  output logic             DMA_ACK,
  // Local memory
  output logic             RAM_RAS_N,
  output logic             RAM_CAS_N,
  output logic             RAM_WE_N,
  output logic             PROM_SEL_N,
  input  wire logic        RAM_PARITY_ERR,
  // System bus
  output logic      [23:0] SYS_ADDR,
  output logic             SYS_MRDC_N,
  output logic             SYS_MWTC_N,
  output logic             UPPER_BYTE_ENABLE_N,
  output logic             UPPER_WORD_ENABLE_N,
  output logic             BYTE_ADDRESS_BIT0,
  output logic             SYS_BREQ0_N,
  input  wire logic        SYS_BPRN_N,
  input  wire logic        SYS_BUSY_N_IN,
  output logic             SYS_BUSY_N_OUT,
  output logic             SYS_BUSY_OE_N,
  output logic             SYSTEM_BUS_LOCK_N,
  input  wire logic        SYS_XACK_N,
  input  wire logic        SYS_IOWC_N,
  input  wire logic [15:0] SYS_IO_ADDR,
  output logic             HOST_CPU_INTERRUPT_N,
  input  wire logic        SYS_PARITY_ERR,
  input  wire logic        SYS_BOUNDS_ERR,
  output logic             XCVR_LO_EN_N,
  output logic             XCVR_HI_EN_N,
  output logic             XCVR_TO_BUS,
  // Board control
  input  wire logic        POWER_FAIL,
  input  wire logic        PROM_LARGE,
  input  wire logic        RAM_LARGE,
  output logic             CHAN_ATTN_IRQ,
  output logic             NMI,
  output logic             CONTROLLER_BOARD_CLEAR_N,
  output logic             DMA_BURST_LIMIT_ENABLE,
  output logic      [15:0] DISK_MODE
);

  // ==========================================
  // Input synchronisers
  logic [25:0] sync_a;
  logic [25:0] sync_b;
  logic        bprn_n;
  logic        busy_n;
  logic        xack_n;
  logic        iowc_n;
  logic        ram_local_parity_error_flag;
  logic        sys_local_parity_error_flag;
  logic        sys_oob;
  logic        pwr_fail;
  logic        prom_large;
  logic        ram_large;
  logic [15:0] io_addr;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sync_a <= 26'h3c00000;
      sync_b <= 26'h3c00000;
    end else begin
      sync_a <= {SYS_BPRN_N, SYS_BUSY_N_IN, SYS_XACK_N, SYS_IOWC_N, RAM_PARITY_ERR,
                 SYS_PARITY_ERR, SYS_BOUNDS_ERR, POWER_FAIL, PROM_LARGE, RAM_LARGE,
                 SYS_IO_ADDR};
      sync_b <= sync_a;
    end
  end

  assign {bprn_n, busy_n, xack_n, iowc_n, ram_local_parity_error_flag, sys_local_parity_error_flag, sys_oob, pwr_fail,
          prom_large, ram_large, io_addr} = sync_b;

  // ==========================================
  // Processor address decode
  // A region may be only partly fitted; beyond the fitted size nothing is selected.
  function automatic logic fits(input logic [17:0] off, input logic big_fit,
                                input logic [17:0] basic, input logic [17:0] big);
    fits = off < (big_fit ? big : basic);
  endfunction

  logic [1:0]  cpu_rgn;
  logic        rom_hit;
  logic        ram_hit;
  logic        cpu_word;
  logic [5:0]  page;
  logic [23:0] cpu_sys_addr;

  assign cpu_rgn      = CPU_ADDR[19:18];
  // PROM sits at the top of its region so the reset vector always lands in it
  assign rom_hit      = (cpu_rgn == RGN_ROM) &&
                        fits(~CPU_ADDR[17:0], prom_large, ROM_BASIC, ROM_BIG);
  assign ram_hit      = (cpu_rgn == RGN_RAM) &&
                        fits(CPU_ADDR[17:0], ram_large, RAM_BASIC, RAM_BIG);
  assign cpu_word     = !CPU_BHE_N && !CPU_ADDR[0];
  assign cpu_sys_addr = {page, CPU_ADDR[17:0]};

  // ==========================================
  // Arbitration and memory sequencing
  fpm_state_t  state;
  fpm_state_t  next_state;
  logic        ref_due;
  logic [7:0]  ref_cnt;
  logic        take_dma;
  logic        take_cpu;
  logic        bus_held;
  logic        x_dma;
  logic        x_wr;
  logic        x_word;
  logic [23:0] x_addr;
  logic        cmd_lock;

  assign take_dma = (state == ST_IDLE) && !ref_due && DMA_REQ;
  assign take_cpu = (state == ST_IDLE) && !ref_due && !DMA_REQ && CPU_REQ;

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ref_due) begin
          next_state = ST_REF1;
        end else if (DMA_REQ) begin
          next_state = ST_BREQ;
        end else if (CPU_REQ) begin
          if (CPU_IO) begin
            next_state = ST_DONE;
          end else if (cpu_rgn == RGN_SYS) begin
            next_state = ST_BREQ;
          end else if (ram_hit) begin
            next_state = ST_RAS;
          end else if (rom_hit) begin
            next_state = ST_ROM;
          end else begin
            next_state = ST_DONE;
          end
        end
      end
      ST_RAS:  next_state = ST_CAS;
      ST_CAS:  next_state = ST_DONE;
      ST_REF1: next_state = ST_REF2;
      ST_REF2: next_state = ST_IDLE;
      ST_ROM:  next_state = ST_DONE;
      ST_BREQ: begin
        if (bus_held || (!bprn_n && busy_n)) begin
          next_state = ST_BCMD;
        end
      end
      ST_BCMD: begin
        if (!xack_n) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Latched transfer of whichever master won
  always_ff @(posedge CLK) begin
    if (SRST) begin
      x_dma  <= 1'b0;
      x_wr   <= 1'b0;
      x_word <= 1'b0;
      x_addr <= '0;
    end else if (take_dma) begin
      x_dma  <= 1'b1;
      x_wr   <= DMA_WR;
      x_word <= DMA_WORD;
      x_addr <= DMA_ADDR;
    end else if (take_cpu) begin
      x_dma  <= 1'b0;
      x_wr   <= CPU_WR;
      x_word <= cpu_word;
      x_addr <= cpu_sys_addr;
    end
  end

  // Refresh request; a new request wins over the clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ref_cnt <= 8'(REF_CYC - 1);
      ref_due <= 1'b0;
    end else begin
      ref_cnt <= (ref_cnt == 8'h00) ? 8'(REF_CYC - 1) : ref_cnt - 8'h01;
      ref_due <= (ref_cnt == 8'h00) || (ref_due && next_state != ST_REF1);
    end
  end

  // Local memory strobes, CAS before RAS on refresh
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RAM_RAS_N  <= 1'b1;
      RAM_CAS_N  <= 1'b1;
      RAM_WE_N   <= 1'b1;
      PROM_SEL_N <= 1'b1;
    end else begin
      RAM_RAS_N  <= !(next_state inside {ST_RAS, ST_CAS, ST_REF2});
      RAM_CAS_N  <= !(next_state inside {ST_CAS, ST_REF1, ST_REF2});
      RAM_WE_N   <= !(next_state == ST_CAS && x_wr);
      PROM_SEL_N <= !(next_state == ST_ROM);
    end
  end

  // Completion pulses; the processor stalls until its own ready
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CPU_READY <= 1'b0;
      DMA_ACK   <= 1'b0;
    end else begin
      CPU_READY <= (next_state == ST_DONE) && !(x_dma && state != ST_IDLE) &&
                   !(state == ST_IDLE && DMA_REQ);
      DMA_ACK   <= (next_state == ST_DONE) && x_dma && state != ST_IDLE;
    end
  end

  // ==========================================
  // System bus exchange and strobes
  // Lock keeps ownership between transfers; other masters starve meanwhile.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bus_held       <= 1'b0;
      SYS_BREQ0_N    <= 1'b1;
      SYS_BUSY_N_OUT <= 1'b0;
      SYS_BUSY_OE_N  <= 1'b1;
    end else begin
      if (state == ST_BREQ && next_state == ST_BCMD) begin
        bus_held <= 1'b1;
      end else if (state == ST_DONE && !cmd_lock) begin
        bus_held <= 1'b0;
      end
      SYS_BREQ0_N    <= !(next_state == ST_BREQ && !bus_held);
      SYS_BUSY_N_OUT <= 1'b0;
      SYS_BUSY_OE_N  <= !((state == ST_BREQ && next_state == ST_BCMD) ||
                          (bus_held && !(state == ST_DONE && !cmd_lock)));
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SYS_ADDR            <= '0;
      SYS_MRDC_N          <= 1'b1;
      SYS_MWTC_N          <= 1'b1;
      UPPER_BYTE_ENABLE_N <= 1'b1;
      UPPER_WORD_ENABLE_N <= 1'b1;
      BYTE_ADDRESS_BIT0   <= 1'b0;
      XCVR_LO_EN_N        <= 1'b1;
      XCVR_HI_EN_N        <= 1'b1;
      XCVR_TO_BUS         <= 1'b0;
    end else begin
      SYS_ADDR            <= x_addr;
      SYS_MRDC_N          <= !(next_state == ST_BCMD && !x_wr);
      SYS_MWTC_N          <= !(next_state == ST_BCMD && x_wr);
      UPPER_BYTE_ENABLE_N <= !(x_word || x_addr[0]);
      UPPER_WORD_ENABLE_N <= !x_addr[1];
      BYTE_ADDRESS_BIT0   <= x_addr[0];
      // Only the D0-D15 transceivers exist; odd bytes ride on the high lane
      XCVR_LO_EN_N        <= !(next_state == ST_BCMD && (x_word || !x_addr[0]));
      XCVR_HI_EN_N        <= !(next_state == ST_BCMD && (x_word || x_addr[0]));
      XCVR_TO_BUS         <= x_wr;
    end
  end

  // ==========================================
  // Local I/O ports
  logic        io_wr;
  logic        io_rd;
  logic        cmd_clr_n;
  logic        cmd_hint;
  logic        cmd_nmi;
  logic        cmd_burst;
  logic [7:0]  clr_cnt;
  logic        flag_pwr;
  logic        flag_mem;
  logic        flag_par;
  logic        err_clr;
  logic [15:0] status_word;

  assign io_wr   = take_cpu && CPU_IO && CPU_WR;
  assign io_rd   = take_cpu && CPU_IO && !CPU_WR;
  assign err_clr = io_wr && CPU_ADDR[15:0] == ERROR_FLAGS_CLEAR_OFS;

  // Only the defined command bits are stored
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_clr_n <= 1'b1;
      cmd_hint  <= 1'b0;
      cmd_nmi   <= 1'b0;
      cmd_burst <= 1'b0;
      cmd_lock  <= 1'b0;
    end else if (io_wr && CPU_ADDR[15:0] == CMD_OFS) begin
      cmd_clr_n <= CPU_WDATA[CMD_CLR_BIT];
      cmd_hint  <= CPU_WDATA[CMD_HINT_BIT];
      cmd_nmi   <= CPU_WDATA[CMD_NMI_BIT];
      cmd_burst <= CPU_WDATA[CMD_BURST_BIT];
      cmd_lock  <= CPU_WDATA[CMD_LOCK_BIT];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      DISK_MODE <= DISK_RST;
      page      <= PAGE_RST;
    end else if (io_wr && CPU_ADDR[15:0] == DISK_OFS) begin
      DISK_MODE <= CPU_WDATA;
    end else if (io_wr && CPU_ADDR[15:0] == PAGE_OFS) begin
      page      <= CPU_WDATA[5:0];
    end
  end

  // Board clear is stretched so a short software pulse still lasts long enough
  always_ff @(posedge CLK) begin
    if (SRST) begin
      clr_cnt                  <= 8'h00;
      CONTROLLER_BOARD_CLEAR_N <= 1'b1;
    end else begin
      if (!cmd_clr_n) begin
        clr_cnt <= 8'(CLR_MIN_CYC - 1);
      end else if (clr_cnt != 8'h00) begin
        clr_cnt <= clr_cnt - 8'h01;
      end
      CONTROLLER_BOARD_CLEAR_N <= cmd_clr_n && clr_cnt == 8'h00;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      HOST_CPU_INTERRUPT_N   <= 1'b1;
      DMA_BURST_LIMIT_ENABLE <= 1'b0;
      SYSTEM_BUS_LOCK_N      <= 1'b1;
    end else begin
      HOST_CPU_INTERRUPT_N   <= !cmd_hint;
      DMA_BURST_LIMIT_ENABLE <= cmd_burst;
      SYSTEM_BUS_LOCK_N      <= !cmd_lock;
    end
  end

  // ==========================================
  // Error flags and NMI; a standing error wins over the clear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      flag_pwr <= 1'b0;
      flag_mem <= 1'b0;
      flag_par <= 1'b0;
      NMI      <= 1'b0;
    end else begin
      flag_pwr <= pwr_fail || (flag_pwr && !err_clr);
      flag_mem <= sys_local_parity_error_flag || sys_oob || (flag_mem && !err_clr);
      flag_par <= ram_local_parity_error_flag || (flag_par && !err_clr);
      NMI      <= cmd_nmi && (flag_pwr || flag_mem || flag_par);
    end
  end

  always_comb begin
    status_word               = 16'h0000;
    status_word[STAT_PWR_BIT] = flag_pwr;
    status_word[STAT_MEM_BIT] = flag_mem;
    status_word[STAT_PAR_BIT] = flag_par;
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      CPU_RDATA <= 16'h0000;
    end else if (io_rd) begin
      CPU_RDATA <= (CPU_ADDR[15:0] == STAT_OFS) ? status_word : 16'h0000;
    end
  end

  // ==========================================
  // Channel attention from the host
  logic iowc_prev;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      iowc_prev     <= 1'b1;
      CHAN_ATTN_IRQ <= 1'b0;
    end else begin
      iowc_prev     <= iowc_n;
      CHAN_ATTN_IRQ <= iowc_prev && !iowc_n && io_addr == ATTN_ADDR;
    end
  end

endmodule // fpm_bus_ctrl

// ==== rtl/fpm_pkg.sv ====
// Constants and types for the file-processor memory and bus control block.
// Assumes a 10 MHz clock; all offsets are local processor I/O addresses.
package fpm_pkg;

  // ==========================================
  // Local I/O ports and the host attention port
  localparam logic [15:0] CMD_OFS    = 16'h0608;
  localparam logic [15:0] DISK_OFS   = 16'h060c;
  localparam logic [15:0] STAT_OFS   = 16'h0700;
  localparam logic [15:0] ERROR_FLAGS_CLEAR_OFS = 16'h0606;
  localparam logic [15:0] PAGE_OFS   = 16'h0604;
  localparam logic [15:0] ATTN_ADDR  = 16'h000e;

  // ==========================================
  // Command and status bit positions
  localparam int CMD_CLR_BIT   = 8;
  localparam int CMD_HINT_BIT  = 10;
  localparam int CMD_NMI_BIT   = 11;
  localparam int CMD_BURST_BIT = 12;
  localparam int CMD_LOCK_BIT  = 13;
  localparam int STAT_PWR_BIT  = 8;
  localparam int STAT_MEM_BIT  = 9;
  localparam int STAT_PAR_BIT  = 10;

  // ==========================================
  // Reset values
  localparam logic [15:0] DISK_RST = 16'h0000;
  localparam logic [5:0]  PAGE_RST = 6'h00;

  // ==========================================
  // Processor address regions and fitted sizes
  localparam logic [1:0]  RGN_RAM   = 2'b00;
  localparam logic [1:0]  RGN_SYS   = 2'b10;
  localparam logic [1:0]  RGN_ROM   = 2'b11;
  localparam logic [17:0] ROM_BASIC = 18'h02000;
  localparam logic [17:0] ROM_BIG   = 18'h04000;
  localparam logic [17:0] RAM_BASIC = 18'h08000;
  localparam logic [17:0] RAM_BIG   = 18'h20000;

  // ==========================================
  // Timing
  localparam int CLK_NS      = 100;
  localparam int CLR_MIN_US  = 25;
  localparam int REFRESH_NS  = 15600;
  localparam int CLR_MIN_CYC = (CLR_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int REF_CYC     = REFRESH_NS / CLK_NS;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RAS, ST_CAS, ST_REF1, ST_REF2, ST_ROM, ST_BREQ, ST_BCMD, ST_DONE
  } fpm_state_t;

endpackage
